// ===== logic/fsr_cfg.svh
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// ==========================================
// instruction codes
`define FSR_CMD_NONE    8'h00
`define FSR_CMD_WREN    8'h06
`define FSR_CMD_WRDI    8'h04
`define FSR_CMD_RDLO    8'h05
`define FSR_CMD_RDHI    8'h35
`define FSR_CMD_WRSR    8'h01
`define FSR_CMD_PROG    8'h02
`define FSR_CMD_SE      8'h20
`define FSR_CMD_BE32    8'h52
`define FSR_CMD_BE64    8'hd8
`define FSR_CMD_CE1     8'h60
`define FSR_CMD_CE2     8'hc7
`define FSR_CMD_SUSP    8'h75
`define FSR_CMD_RESUME  8'h7a
`define FSR_CMD_RSTEN   8'h66
`define FSR_CMD_RST     8'h99
`define FSR_CMD_QOUT    8'h6b
`define FSR_CMD_QIO     8'heb

// ==========================================
// status word bit positions
`define FSR_POS_BUSY    0
`define FSR_POS_WEL     1
`define FSR_POS_BP      2
`define FSR_POS_STATUS_GUARD_MODE_LO    7
`define FSR_POS_STATUS_GUARD_MODE_HI    8
`define FSR_POS_QE      9
`define FSR_POS_PSUS    10
`define FSR_POS_LB      11
`define FSR_POS_CMP     14
`define FSR_POS_ESUS    15

// ==========================================
// factory defaults and timing
`define FSR_NV_DEFAULT  1'b0
`define FSR_OP_CYCLES   16'h03e8

`endif

// ===== logic/fsr_link_if.sv
`timescale 1ns/1ps

interface fsr_link_if;
    logic       byte_vld;
    logic [7:0] rx_byte;
    logic       frame_end;
    logic [7:0] tx_byte;
    logic       tx_en;

    modport fe   (output byte_vld, output rx_byte, output frame_end,
                  input tx_byte, input tx_en);
    modport core (input byte_vld, input rx_byte, input frame_end,
                  output tx_byte, output tx_en);
endinterface : fsr_link_if

// ===== logic/fsr_pkg.sv
package fsr_pkg;

    // ==========================================
    // command phase within a frame
    typedef enum logic [2:0] {
        FSR_ST_CMD   = 3'b000,
        FSR_ST_ADDR  = 3'b001,
        FSR_ST_WDATA = 3'b010,
        FSR_ST_READ  = 3'b011,
        FSR_ST_SKIP  = 3'b100
    } fsr_state_t;

    // ==========================================
    // internal operation in flight
    typedef enum logic [1:0] {
        FSR_OP_NONE  = 2'b00,
        FSR_OP_WSR   = 2'b01,
        FSR_OP_PROG  = 2'b10,
        FSR_OP_ERASE = 2'b11
    } fsr_op_t;

endpackage : fsr_pkg

// ===== logic/fsr_spi_fe.sv
`timescale 1ns/1ps

module fsr_spi_fe (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_n_i,
    input  wire logic ce_i,
    // serial pins
    input  wire logic spi_sclk_i,
    input  wire logic spi_cs_n_i,
    input  wire logic spi_si_i,
    output logic      spi_so_o,
    output logic      spi_so_oe_n_o,
    // byte side
    fsr_link_if.fe    lnk
);

    // ==========================================
    // synchronisers; stage 3 of sclk only for edge finding
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic cs_s1_r, cs_s2_r, si_s1_r, si_s2_r;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
            {cs_s1_r, cs_s2_r}                <= 2'h3;
            {si_s1_r, si_s2_r}                <= 2'h0;
        end else if (ce_i) begin
            {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {spi_sclk_i, sclk_s1_r, sclk_s2_r};
            {cs_s1_r, cs_s2_r}                <= {spi_cs_n_i, cs_s1_r};
            {si_s1_r, si_s2_r}                <= {spi_si_i, si_s1_r};
        end
    end

    // ==========================================
    // shifter
    logic       rise, fall, sel;
    logic [2:0] bcnt_r, bcnt_nxt;
    logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic       so_r, so_nxt, oe_n_r, oe_n_nxt;
    logic       bv_r, bv_nxt, fe_r, fe_nxt, sel_r, sel_nxt;

    assign rise = sclk_s2_r & ~sclk_s3_r;
    assign fall = ~sclk_s2_r & sclk_s3_r;
    assign sel  = ~cs_s2_r;

    always_comb begin
        bcnt_nxt = bcnt_r;
        rx_nxt   = rx_r;
        tx_nxt   = tx_r;
        so_nxt   = so_r;
        bv_nxt   = 1'b0;
        fe_nxt   = sel_r & ~sel;
        sel_nxt  = sel;
        oe_n_nxt = 1'b1;
        if (!sel) begin
            bcnt_nxt = 3'h0;
        end else begin
            oe_n_nxt = ~lnk.tx_en;
            if (rise) begin
                rx_nxt   = {rx_r[6:0], si_s2_r};
                bcnt_nxt = bcnt_r + 3'h1;
                bv_nxt   = (bcnt_r == 3'h7);
            end
            // msb of a new byte goes out on the first falling edge after a boundary
            if (fall) begin
                if (bcnt_r == 3'h0) begin
                    so_nxt = lnk.tx_byte[7];
                    tx_nxt = {lnk.tx_byte[6:0], 1'b0};
                end else begin
                    so_nxt = tx_r[7];
                    tx_nxt = {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            bcnt_r <= 3'h0;
            rx_r   <= 8'h00;
            tx_r   <= 8'h00;
            so_r   <= 1'b0;
            oe_n_r <= 1'b1;
            bv_r   <= 1'b0;
            fe_r   <= 1'b0;
            sel_r  <= 1'b0;
        end else if (ce_i) begin
            bcnt_r <= bcnt_nxt;
            rx_r   <= rx_nxt;
            tx_r   <= tx_nxt;
            so_r   <= so_nxt;
            oe_n_r <= oe_n_nxt;
            bv_r   <= bv_nxt;
            fe_r   <= fe_nxt;
            sel_r  <= sel_nxt;
        end
    end

    assign lnk.byte_vld  = bv_r;
    assign lnk.rx_byte   = rx_r;
    assign lnk.frame_end = fe_r;
    assign spi_so_o      = so_r;
    assign spi_so_oe_n_o = oe_n_r;

endmodule : fsr_spi_fe

// ===== logic/fsr_status_regs.sv
`timescale 1ns/1ps
`include "fsr_cfg.svh"

module fsr_status_regs (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       ce_i,
    // serial link
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_si_i,
    input  wire logic       wp_n_i,
    output logic            spi_so_o,
    output logic            spi_so_oe_n_o,
    // status to the rest of the device
    output logic            busy_o,
    output logic            quad_sel_o,
    output logic [2:0]      sec_lock_o,
    output logic            quad_read_go_o
);

    // ==========================================
    // front end
    fsr_link_if lnk ();

    fsr_spi_fe u_fe (
        .sys_clk_i     (sys_clk_i),
        .reset_n_i     (reset_n_i),
        .ce_i          (ce_i),
        .spi_sclk_i    (spi_sclk_i),
        .spi_cs_n_i    (spi_cs_n_i),
        .spi_si_i      (spi_si_i),
        .spi_so_o      (spi_so_o),
        .spi_so_oe_n_o (spi_so_oe_n_o),
        .lnk           (lnk.fe)
    );

    logic wp_s1_r, wp_s2_r;

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            {wp_s1_r, wp_s2_r} <= 2'h0;
        end else if (ce_i) begin
            {wp_s1_r, wp_s2_r} <= {wp_n_i, wp_s1_r};
        end
    end

    // ==========================================
    // decode helpers
    function automatic logic fsr_is_arr(input logic [7:0] op);
        fsr_is_arr = (op == `FSR_CMD_PROG) || (op == `FSR_CMD_SE) ||
                     (op == `FSR_CMD_BE32) || (op == `FSR_CMD_BE64);
    endfunction : fsr_is_arr

    // one bit per 64k block; a partly covered block counts as protected
    function automatic logic [7:0] fsr_prot_mask(input logic [4:0] bp, input logic cmp);
        logic [7:0] m;
        logic       part;
        m    = 8'h00;
        part = 1'b0;
        if (!bp[4]) begin
            if (bp[2])                 m = 8'hff;
            else if (bp[1:0] == 2'h1)  m = bp[3] ? 8'h01 : 8'h80;
            else if (bp[1:0] == 2'h2)  m = bp[3] ? 8'h03 : 8'hc0;
            else if (bp[1:0] == 2'h3)  m = bp[3] ? 8'h0f : 8'hf0;
        end else if (bp[2:0] == 3'h7) begin
            m = 8'hff;
        end else if (bp[2:0] != 3'h0) begin
            m    = bp[3] ? 8'h01 : 8'h80;
            part = 1'b1;
        end
        if (cmp) begin
            m = part ? 8'hff : ~m;
        end
        fsr_prot_mask = m;
    endfunction : fsr_prot_mask

    // ==========================================
    // register state
    fsr_pkg::fsr_state_t st_r, st_nxt;
    fsr_pkg::fsr_op_t    op_r, op_nxt;
    logic [7:0]  opc_r, opc_nxt;
    logic [1:0]  nb_r, nb_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic [15:0] wd_r, wd_nxt, tmr_r, tmr_nxt;
    logic [7:0]  tx_r, tx_nxt;
    logic        txen_r, txen_nxt, qrd_r, qrd_nxt, rsten_r, rsten_nxt;
    logic        busy_r, busy_nxt, wel_r, wel_nxt;
    logic [4:0]  bp_r, bp_nxt;
    logic [1:0]  srp_r, srp_nxt;
    logic        qe_r, qe_nxt, cmp_r, cmp_nxt;
    logic [2:0]  lb_r, lb_nxt;
    logic        esus_r, esus_nxt, psus_r, psus_nxt;

    logic [15:0] sr_w;
    logic        wp_hi, wsr_ok, arr_ok, chip_ok, hit;
    logic [7:0]  prot_m;

    always_comb begin
        sr_w                      = 16'h0000;
        sr_w[`FSR_POS_BUSY]       = busy_r;
        sr_w[`FSR_POS_WEL]        = wel_r;
        sr_w[`FSR_POS_BP +: 5]    = bp_r;
        sr_w[`FSR_POS_STATUS_GUARD_MODE_LO]       = srp_r[0];
        sr_w[`FSR_POS_STATUS_GUARD_MODE_HI]       = srp_r[1];
        sr_w[`FSR_POS_QE]         = qe_r;
        sr_w[`FSR_POS_PSUS]       = psus_r;
        sr_w[`FSR_POS_LB +: 3]    = lb_r;
        sr_w[`FSR_POS_CMP]        = cmp_r;
        sr_w[`FSR_POS_ESUS]       = esus_r;
    end

    // with quad select set the pin is a data line, so it cannot lock
    assign wp_hi   = qe_r | wp_s2_r;
    assign wsr_ok  = wel_r & ~busy_r &
                     ((srp_r == 2'b00) | ((srp_r == 2'b01) & wp_hi));
    assign arr_ok  = wel_r & ~busy_r & ~esus_r & ~psus_r;
    assign chip_ok = ((bp_r[2:0] == 3'h0) & ~cmp_r) |
                     ((bp_r[2:0] == 3'h7) & cmp_r);
    assign prot_m  = fsr_prot_mask(bp_r, cmp_r);
    assign hit     = prot_m[addr_r[18:16]];

    always_comb begin
        st_nxt    = st_r;
        op_nxt    = op_r;
        opc_nxt   = opc_r;
        nb_nxt    = nb_r;
        addr_nxt  = addr_r;
        wd_nxt    = wd_r;
        tmr_nxt   = tmr_r;
        tx_nxt    = tx_r;
        txen_nxt  = txen_r;
        qrd_nxt   = 1'b0;
        rsten_nxt = rsten_r;
        busy_nxt  = busy_r;
        wel_nxt   = wel_r;
        bp_nxt    = bp_r;
        srp_nxt   = srp_r;
        qe_nxt    = qe_r;
        cmp_nxt   = cmp_r;
        lb_nxt    = lb_r;
        esus_nxt  = esus_r;
        psus_nxt  = psus_r;

        if (busy_r) begin
            if (tmr_r == 16'h0001) begin
                busy_nxt = 1'b0;
                wel_nxt  = 1'b0;
                op_nxt   = fsr_pkg::FSR_OP_NONE;
                tmr_nxt  = 16'h0000;
            end else begin
                tmr_nxt = tmr_r - 16'h0001;
            end
        end

        // live value, so polling the busy flag sees it fall mid-frame
        if (st_r == fsr_pkg::FSR_ST_READ) begin
            tx_nxt = (opc_r == `FSR_CMD_RDLO) ? sr_w[7:0] : sr_w[15:8];
        end

        if (lnk.byte_vld) begin
            case (st_r)
                fsr_pkg::FSR_ST_CMD: begin
                    opc_nxt  = lnk.rx_byte;
                    nb_nxt   = 2'h0;
                    txen_nxt = (lnk.rx_byte == `FSR_CMD_RDLO) || (lnk.rx_byte == `FSR_CMD_RDHI);
                    if (txen_nxt)
                        st_nxt = fsr_pkg::FSR_ST_READ;
                    else if (lnk.rx_byte == `FSR_CMD_WRSR)
                        st_nxt = fsr_pkg::FSR_ST_WDATA;
                    else if (fsr_is_arr(lnk.rx_byte))
                        st_nxt = fsr_pkg::FSR_ST_ADDR;
                    else
                        st_nxt = fsr_pkg::FSR_ST_SKIP;
                    if ((lnk.rx_byte == `FSR_CMD_QOUT || lnk.rx_byte == `FSR_CMD_QIO) && qe_r)
                        qrd_nxt = 1'b1;
                end
                fsr_pkg::FSR_ST_ADDR: begin
                    addr_nxt = {addr_r[15:0], lnk.rx_byte};
                    if (nb_r != 2'h3) nb_nxt = nb_r + 2'h1;
                end
                fsr_pkg::FSR_ST_WDATA: begin
                    if (nb_r == 2'h0) wd_nxt[7:0] = lnk.rx_byte;
                    if (nb_r == 2'h1) wd_nxt[15:8] = lnk.rx_byte;
                    if (nb_r != 2'h2) nb_nxt = nb_r + 2'h1;
                end
                default: ;
            endcase
        end

        // instructions act when chip select rises
        if (lnk.frame_end) begin
            st_nxt    = fsr_pkg::FSR_ST_CMD;
            txen_nxt  = 1'b0;
            opc_nxt   = `FSR_CMD_NONE;
            rsten_nxt = (opc_r == `FSR_CMD_RSTEN);
            case (opc_r)
                `FSR_CMD_WREN: begin
                    if (!busy_r) wel_nxt = 1'b1;
                end
                `FSR_CMD_WRDI: begin
                    if (!busy_r) wel_nxt = 1'b0;
                end
                `FSR_CMD_WRSR: begin
                    if (wsr_ok && nb_r != 2'h0) begin
                        bp_nxt     = wd_r[`FSR_POS_BP +: 5];
                        srp_nxt[0] = wd_r[`FSR_POS_STATUS_GUARD_MODE_LO];
                        if (nb_r == 2'h2) begin
                            srp_nxt[1] = wd_r[`FSR_POS_STATUS_GUARD_MODE_HI];
                            qe_nxt     = wd_r[`FSR_POS_QE];
                            cmp_nxt    = wd_r[`FSR_POS_CMP];
                            lb_nxt     = lb_r | wd_r[`FSR_POS_LB +: 3];
                        end
                        busy_nxt = 1'b1;
                        op_nxt   = fsr_pkg::FSR_OP_WSR;
                        tmr_nxt  = `FSR_OP_CYCLES;
                    end
                end
                `FSR_CMD_PROG, `FSR_CMD_SE, `FSR_CMD_BE32, `FSR_CMD_BE64: begin
                    if (arr_ok && nb_r == 2'h3 && !hit) begin
                        busy_nxt = 1'b1;
                        op_nxt   = (opc_r == `FSR_CMD_PROG) ? fsr_pkg::FSR_OP_PROG
                                                            : fsr_pkg::FSR_OP_ERASE;
                        tmr_nxt  = `FSR_OP_CYCLES;
                    end
                end
                `FSR_CMD_CE1, `FSR_CMD_CE2: begin
                    if (arr_ok && chip_ok) begin
                        busy_nxt = 1'b1;
                        op_nxt   = fsr_pkg::FSR_OP_ERASE;
                        tmr_nxt  = `FSR_OP_CYCLES;
                    end
                end
                `FSR_CMD_SUSP: begin
                    if (busy_r && tmr_r != 16'h0001) begin
                        if (op_r == fsr_pkg::FSR_OP_PROG) begin
                            psus_nxt = 1'b1;
                            busy_nxt = 1'b0;
                        end else if (op_r == fsr_pkg::FSR_OP_ERASE) begin
                            esus_nxt = 1'b1;
                            busy_nxt = 1'b0;
                        end
                    end
                end
                `FSR_CMD_RESUME: begin
                    if (esus_r || psus_r) begin
                        esus_nxt = 1'b0;
                        psus_nxt = 1'b0;
                        busy_nxt = 1'b1;
                    end
                end
                `FSR_CMD_RST: begin
                    if (rsten_r) begin
                        esus_nxt = 1'b0;
                        psus_nxt = 1'b0;
                        wel_nxt  = 1'b0;
                        busy_nxt = 1'b0;
                        op_nxt   = fsr_pkg::FSR_OP_NONE;
                        tmr_nxt  = 16'h0000;
                    end
                end
                default: ;
            endcase
        end
    end

    // power cycle: volatile and non-volatile bits all clear, every protect mode returns to 00
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            st_r    <= fsr_pkg::FSR_ST_CMD;
            op_r    <= fsr_pkg::FSR_OP_NONE;
            opc_r   <= `FSR_CMD_NONE;
            nb_r    <= 2'h0;
            addr_r  <= 24'h000000;
            wd_r    <= 16'h0000;
            tmr_r   <= 16'h0000;
            tx_r    <= 8'h00;
            txen_r  <= 1'b0;
            qrd_r   <= 1'b0;
            rsten_r <= 1'b0;
            busy_r  <= 1'b0;
            wel_r   <= 1'b0;
            bp_r    <= {5{`FSR_NV_DEFAULT}};
            srp_r   <= {2{`FSR_NV_DEFAULT}};
            qe_r    <= `FSR_NV_DEFAULT;
            cmp_r   <= `FSR_NV_DEFAULT;
            lb_r    <= {3{`FSR_NV_DEFAULT}};
            esus_r  <= 1'b0;
            psus_r  <= 1'b0;
        end else if (ce_i) begin
            st_r    <= st_nxt;
            op_r    <= op_nxt;
            opc_r   <= opc_nxt;
            nb_r    <= nb_nxt;
            addr_r  <= addr_nxt;
            wd_r    <= wd_nxt;
            tmr_r   <= tmr_nxt;
            tx_r    <= tx_nxt;
            txen_r  <= txen_nxt;
            qrd_r   <= qrd_nxt;
            rsten_r <= rsten_nxt;
            busy_r  <= busy_nxt;
            wel_r   <= wel_nxt;
            bp_r    <= bp_nxt;
            srp_r   <= srp_nxt;
            qe_r    <= qe_nxt;
            cmp_r   <= cmp_nxt;
            lb_r    <= lb_nxt;
            esus_r  <= esus_nxt;
            psus_r  <= psus_nxt;
        end
    end

    assign lnk.tx_byte    = tx_r;
    assign lnk.tx_en      = txen_r;
    assign busy_o         = busy_r;
    assign quad_sel_o     = qe_r;
    assign sec_lock_o     = lb_r;
    assign quad_read_go_o = qrd_r;

    // ==========================================
    // assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    logic fex;
    assign fex = lnk.frame_end & ce_i;

    wsr_start_a: assert property (
        fex && opc_r == `FSR_CMD_WRSR && nb_r != 2'h0 && wel_r && !busy_r && srp_r == 2'b00
        |=> busy_r && op_r == fsr_pkg::FSR_OP_WSR && tmr_r == `FSR_OP_CYCLES)
        else $error("status write did not start busy");
    latch_gate_a: assert property (
        fex && !wel_r && !busy_r && opc_r != `FSR_CMD_RESUME |=> !busy_r)
        else $error("operation started without write latch");
    bp_write_a: assert property (
        fex && opc_r == `FSR_CMD_WRSR && nb_r != 2'h0 && wel_r && !busy_r && srp_r == 2'b00
        |=> bp_r == $past(wd_r[6:2]))
        else $error("protect bits not written");
    hw_lock_a: assert property (
        fex && srp_r == 2'b01 && !qe_r && !wp_s2_r |=> $stable(bp_r) && $stable(srp_r))
        else $error("status changed while pin locked");
    mode_lock_a: assert property (
        fex && srp_r[1] |=> $stable({bp_r, srp_r, qe_r, cmp_r, lb_r}))
        else $error("status changed in lock-down mode");
    chip_guard_a: assert property (
        fex && (opc_r == `FSR_CMD_CE1 || opc_r == `FSR_CMD_CE2) && !busy_r &&
        !(((bp_r[2:0] == 3'h0) && !cmp_r) || ((bp_r[2:0] == 3'h7) && cmp_r)) |=> !busy_r)
        else $error("chip erase ran while protected");
    lock_keep_a: assert property (
        ce_i |=> (($past(lb_r) & ~lb_r) == 3'h0))
        else $error("security lock bit cleared");
    prog_susp_a: assert property (
        fex && opc_r == `FSR_CMD_SUSP && busy_r && tmr_r != 16'h0001 &&
        op_r == fsr_pkg::FSR_OP_PROG |=> psus_r && !busy_r && !esus_r)
        else $error("program suspend flag not set");
    resume_clr_a: assert property (
        fex && opc_r == `FSR_CMD_RESUME && (esus_r || psus_r) |=> !esus_r && !psus_r && busy_r)
        else $error("resume did not clear suspend");
    quad_gate_a: assert property (
        quad_read_go_o |-> qe_r && $past(st_r) == fsr_pkg::FSR_ST_CMD)
        else $error("quad read accepted without quad select");
    op_done_a: assert property (
        ce_i && busy_r && tmr_r == 16'h0001 && !lnk.frame_end |=> !busy_r && !wel_r)
        else $error("completion left busy or latch set");

    wsr_cov_c:  cover property (fex && opc_r == `FSR_CMD_WRSR && wsr_ok);
    susp_cov_c: cover property (esus_r ##1 !esus_r);
    done_cov_c: cover property (busy_r ##1 !busy_r);
    prot_cov_c: cover property (fex && fsr_is_arr(opc_r) && arr_ok && hit);

endmodule : fsr_status_regs

// ===== verification/flash_status_protect_regs_test.sv
`timescale 1ns/1ps

module flash_status_protect_regs_test;
    logic        sys_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        wp_n_i    = 1'b1;
    logic        sclk, cs_n, si, so, busy, quad, qgo;
    logic [2:0]  lock;
    logic [15:0] exp_sr, v;
    logic [7:0]  rd;
    int          fail_count = 0;
    int          check_count = 0;
    int          seed = 17585;
    int          qcnt = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (qgo === 1'b1) qcnt++;

    fsr_status_regs i_fsr_status_regs (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .ce_i(1'b1), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_si_i(si), .wp_n_i(wp_n_i),
        .spi_so_o(so), .spi_so_oe_n_o(), .busy_o(busy), .quad_sel_o(quad),
        .sec_lock_o(lock), .quad_read_go_o(qgo));
    fsr_spi_host i_fsr_spi_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));

    // ==========================================
    // checks
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : check
    task test_done;
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task cmd(input logic [31:0] d, input int n);
        // pins move off the sampling edge
        @(negedge sys_clk_i);
        i_fsr_spi_host.frame(d, n, rd);
    endtask : cmd
    task cmp_sr(input string nm);
        cmd(32'h05000000, 2);
        v[7:0] = rd;
        cmd(32'h35000000, 2);
        v[15:8] = rd;
        check(nm, v, exp_sr);
    endtask : cmp_sr
    task wait_idle;
        repeat (1100) if (busy !== 1'b0) @(posedge sys_clk_i);
        check("busy", busy, 16'h0);
    endtask : wait_idle
    task pwr_cycle;
        reset_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        exp_sr = 16'h0;
        cmp_sr("reset status");
    endtask : pwr_cycle
    task wr_sr(input logic [7:0] lo, input logic [7:0] hi);
        logic ok;
        @(posedge sys_clk_i);
        ok = exp_sr[8:7] == 2'b00 || (exp_sr[8:7] == 2'b01 && (wp_n_i || exp_sr[9]));
        cmd(32'h06000000, 1);
        cmd({8'h01, lo, hi, 8'h00}, 3);
        repeat (2) @(posedge sys_clk_i);
        check("busy start", busy, ok);
        exp_sr[1] = !ok;
        if (ok) exp_sr[14:2] = {hi[6], exp_sr[13:11] | hi[5:3], exp_sr[10], hi[1:0], lo[7:2]};
        wait_idle();
        cmp_sr("status write");
        check("locks", lock, exp_sr[13:11]);
        check("quad", quad, exp_sr[9]);
        qcnt = 0;
        cmd(32'h6b000000, 1);
        check("quad read", qcnt, exp_sr[9]);
    endtask : wr_sr

    initial begin
        #2ms;
        fail_count++;
        test_done();
    end

    initial begin
        pwr_cycle();
        cmd(32'h017c0000, 2);
        repeat (6) @(posedge sys_clk_i);
        cmp_sr("no latch");
        wr_sr(8'h80, 8'h00);
        wp_n_i <= 1'b0;
        wr_sr(8'h7c, 8'h00);
        wp_n_i <= 1'b1;
        wr_sr(8'h84, 8'h00);
        wr_sr(8'h00, 8'h01);
        wr_sr(8'h7c, 8'h40);
        pwr_cycle();
        cmd(32'h06000000, 1);
        cmd(32'h02000000, 4);
        cmd(32'h75000000, 1);
        exp_sr[10] = 1'b1;
        exp_sr[1] = 1'b1;
        cmp_sr("suspend");
        cmd(32'h7a000000, 1);
        exp_sr[10] = 1'b0;
        check("resume busy", busy, 16'h1);
        wait_idle();
        exp_sr[1] = 1'b0;
        cmp_sr("program done");
        // block 0 guarded, block 7 free once inverted
        wr_sr(8'h04, 8'h40);
        cmd(32'h06000000, 1);
        cmd(32'h02000000, 4);
        check("guarded program", busy, 16'h0);
        cmd(32'h60000000, 1);
        check("guarded chip erase", busy, 16'h0);
        cmd(32'h02070000, 4);
        check("inverted program", busy, 16'h1);
        wait_idle();
        exp_sr[1] = 1'b0;
        // status_guard_mode_hi masked off: wp is driven, never tied, so quad is safe
        for (int j = 0; j < 8; j++) begin
            wp_n_i <= $random(seed);
            wr_sr($random(seed), $random(seed) & 8'h7a);
        end
        pwr_cycle();
        wr_sr(8'h80, 8'h01);
        wr_sr(8'h00, 8'h00);
        test_done();
    end
endmodule : flash_status_protect_regs_test

// ===== verification/fsr_spi_host.sv
`timescale 1ns/1ps

module fsr_spi_host (
    // serial pins
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // mode 0 frame, msb first; rd keeps the last byte seen on so
    task frame(input logic [31:0] d, input int n, output logic [7:0] rd);
        cs_n_o = 1'b0;
        for (int i = 31; i >= 32 - 8 * n; i--) begin
            si_o = d[i];
            #100 sclk_o = 1'b1;
            rd = {rd[6:0], so_i};
            #100 sclk_o = 1'b0;
        end
        // no pull on si: leave a changed level, not the last bit
        si_o = ~si_o;
        #100 cs_n_o = 1'b1;
        #100;
    endtask : frame
endmodule : fsr_spi_host
